/* hdl/ldc_pkg.sv */
/*
  shared constants of the led dimming configuration register bank:
  register offsets, reset values, field positions and timing counts.
  assumes a 10 MHz core clock and an 8-bit register address from the
  serial interface engine.
*/
package ldc_pkg;

  // register offsets
  localparam logic [7:0]  OFS_HOST_BRT   = 8'h00;
  localparam logic [7:0]  OFS_CURRENT    = 8'h02;
  localparam logic [7:0]  OFS_DIMSPREAD  = 8'h04;
  localparam logic [7:0]  OFS_SHORT      = 8'h06;

  // reset values
  localparam logic [15:0] RST_HOST_BRT   = 16'h0000;
  localparam logic [15:0] RST_CURRENT    = 16'h0fff;
  localparam logic [15:0] RST_DIMSPREAD  = 16'h08a3;
  localparam logic [15:0] RST_SHORT      = 16'h0100;
  localparam logic [15:0] LFSR_SEED      = 16'hace1;

  // field positions
  localparam int CUR_LSB     = 0;
  localparam int CUR_MSB     = 11;
  localparam int PSEUDO_BIT  = 14;
  localparam int RATE_LSB    = 12;
  localparam int RANGE_LSB   = 10;
  localparam int SRC_LSB     = 8;
  localparam int RAMP_LSB    = 5;
  localparam int DITHER_LSB  = 2;
  localparam int SMOOTH_BIT  = 1;

  // brightness source codes
  localparam logic [1:0]  SRC_PWM        = 2'h0;
  localparam logic [1:0]  SRC_HOST       = 2'h2;

  // ramp durations in ms for codes 1 to 7
  localparam logic [9:0]  RAMP_MS_1      = 10'h001;
  localparam logic [9:0]  RAMP_MS_2      = 10'h002;
  localparam logic [9:0]  RAMP_MS_3      = 10'h032;
  localparam logic [9:0]  RAMP_MS_4      = 10'h064;
  localparam logic [9:0]  RAMP_MS_5      = 10'h0c8;
  localparam logic [9:0]  RAMP_MS_6      = 10'h12c;
  localparam logic [9:0]  RAMP_MS_7      = 10'h1f4;

  // timing
  localparam int unsigned CLK_HZ         = 10_000_000;
  localparam int unsigned CLK_PERIOD_NS  = 100;
  localparam int unsigned MS_NS          = 1_000_000;
  localparam int unsigned MS_CYC         = MS_NS / CLK_PERIOD_NS;
  localparam int unsigned RAMP_STEPS     = 256;
  localparam int unsigned MOD_STEPS      = 128;
  localparam int unsigned MOD_HZ_0       = 200;
  localparam int unsigned MOD_HZ_1       = 500;
  localparam int unsigned MOD_HZ_2       = 800;
  localparam int unsigned MOD_HZ_3       = 1200;
  localparam logic [8:0]  MOD_CYC_0 = 9'(CLK_HZ / (MOD_HZ_0 * MOD_STEPS));
  localparam logic [8:0]  MOD_CYC_1 = 9'(CLK_HZ / (MOD_HZ_1 * MOD_STEPS));
  localparam logic [8:0]  MOD_CYC_2 = 9'(CLK_HZ / (MOD_HZ_2 * MOD_STEPS));
  localparam logic [8:0]  MOD_CYC_3 = 9'(CLK_HZ / (MOD_HZ_3 * MOD_STEPS));

endpackage

/* hdl/ldc_ramp.sv */
/*
  brightness ramp: moves the output level toward the target in 256
  steps spread over the selected duration, with optional smoothing.
  assumes target is stable between changes and clk runs at 10 MHz.
*/
`timescale 1ns/10ps
module ldc_ramp #(
  parameter int unsigned MS_CYC = ldc_pkg::MS_CYC
) (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // control
  input  wire logic [15:0] target,
  input  wire logic [2:0]  dur_code,
  input  wire logic        smooth,
  // result
  output logic      [15:0] level
);

  localparam int unsigned PRE_CYC = (MS_CYC / ldc_pkg::RAMP_STEPS > 0) ?
                                    MS_CYC / ldc_pkg::RAMP_STEPS : 1;
  localparam logic [15:0] PRE_LAST = 16'(PRE_CYC - 1);

  function automatic logic [9:0] ramp_ms(input logic [2:0] c);
    unique case (c)
      3'h1:    ramp_ms = ldc_pkg::RAMP_MS_1;
      3'h2:    ramp_ms = ldc_pkg::RAMP_MS_2;
      3'h3:    ramp_ms = ldc_pkg::RAMP_MS_3;
      3'h4:    ramp_ms = ldc_pkg::RAMP_MS_4;
      3'h5:    ramp_ms = ldc_pkg::RAMP_MS_5;
      3'h6:    ramp_ms = ldc_pkg::RAMP_MS_6;
      3'h7:    ramp_ms = ldc_pkg::RAMP_MS_7;
      default: ramp_ms = 10'h001;
    endcase
  endfunction

  logic        [15:0] pre_cnt;
  logic        [10:0] unit_cnt;
  logic        [15:0] lin;
  logic        [15:0] filt;
  logic        [15:0] prev_target;
  logic        [15:0] step;

  wire         [9:0]  unit_ms   = ramp_ms(dur_code);
  // advanced mode doubles the step interval
  wire         [10:0] unit_len  = smooth ? {unit_ms, 1'b0}
                                         : {1'b0, unit_ms};
  wire         [10:0] unit_last = unit_len - 11'h001;
  wire                pre_tick  = (pre_cnt == PRE_LAST);
  // >= so a shorter duration picked mid-unit never waits for a wrap
  wire                unit_end  = pre_tick && (unit_cnt >= unit_last);
  wire                bypass    = (dur_code == 3'h0);
  wire                step_tick = unit_end && !bypass;
  wire         [15:0] abs_diff  = (target > prev_target) ?
                                  target - prev_target : prev_target - target;
  wire         [15:0] new_step  = (abs_diff[15:8] == 8'h00) ? 16'h0001
                                  : {8'h00, abs_diff[15:8]};
  wire         [15:0] up_room   = target - lin;
  wire         [15:0] dn_room   = lin - target;
  wire         [15:0] next_lin  = (lin < target) ?
                                  ((up_room > step) ? lin + step : target) :
                                  ((dn_room > step) ? lin - step : target);
  wire signed  [16:0] fdiff     = $signed({1'b0, next_lin})
                                  - $signed({1'b0, filt});
  wire signed  [16:0] fsum      = $signed({1'b0, filt}) + (fdiff >>> 2);
  wire                fnear     = (fdiff < 17'sd4) && (fdiff > -17'sd4);
  wire         [15:0] next_filt = fnear ? next_lin : fsum[15:0];

  assign level = smooth ? filt : lin;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pre_cnt  <= 16'h0000;
      unit_cnt <= 11'h000;
    end else begin
      pre_cnt  <= pre_tick ? 16'h0000 : pre_cnt + 16'h0001;
      if (unit_end)
        unit_cnt <= 11'h000;
      else if (pre_tick)
        unit_cnt <= unit_cnt + 11'h001;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prev_target <= 16'h0000;
      step        <= 16'h0001;
    end else if (target != prev_target) begin
      prev_target <= target;
      step        <= new_step;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      lin  <= 16'h0000;
      filt <= 16'h0000;
    end else if (bypass) begin
      lin  <= target;
      filt <= target;
    end else if (step_tick) begin
      lin  <= next_lin;
      filt <= next_filt;
    end
  end

  a_ramp_hold: assert property (@(posedge clk) disable iff (!rst_n)
    (!bypass && !step_tick) |=> ($stable(lin) && $stable(filt)))
    else $error("ramp level moved between steps");

  a_ramp_bypass: assert property (@(posedge clk) disable iff (!rst_n)
    bypass |=> (lin == $past(target)))
    else $error("disabled ramp did not follow target");

  a_step_spacing: assert property (@(posedge clk) disable iff (!rst_n)
    (step_tick && smooth && $stable(smooth)) |=> !step_tick [*8])
    else $error("advanced ramp steps too close");

endmodule // ldc_ramp

/* hdl/ldc_config_regs.sv */
/*
  configuration register bank of a six-channel led driver: current
  level, spread spectrum, brightness source, ramp and dither settings.
  assumes a register access port driven by the serial interface engine
  and a measured pwm duty input, both synchronous to clk.
*/
// What this block does
// - 12-bit shared current level, resets all ones
// - bit 14 enables pseudo-random spread modulation
// - bits 13-12 pick modulation rate 200Hz-1.2kHz
// - bits 11-10 pick spread deviation, reset code 2
// - bits 9-8 pick pwm pin or host brightness
// - bits 7-5 pick ramp duration, zero disables
// - advanced ramp lengthens and smooths transitions
// - bits 4-2 pick zero to four dither bits
// - bit 1 selects advanced ramp, resets set
// - config resets 08a3h, short detect 0100h
// - host brightness register at 00h, 16 bits
`timescale 1ns/10ps
module ldc_config_regs #(
  parameter int unsigned MS_CYC = ldc_pkg::MS_CYC
) (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // register access port
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [15:0] reg_wdata,
  output logic      [15:0] reg_rdata,
  output logic             reg_rd_valid,
  // measured pwm pin duty
  input  wire logic [15:0] pwm_duty,
  // current sink setting
  output logic      [11:0] global_current_level,
  // boost spread spectrum
  output logic             spread_pseudo_enable,
  output logic      [1:0]  spread_modulation_rate,
  output logic      [1:0]  spread_range,
  output logic      [6:0]  boost_oscillator_offset,
  // brightness path
  output logic      [1:0]  brightness_source_select,
  output logic      [2:0]  ramp_duration_select,
  output logic      [2:0]  dither_depth,
  output logic             smooth_ramp_enable,
  output logic      [15:0] host_brightness_value,
  output logic      [15:0] brightness_duty,
  // short detect configuration
  output logic      [15:0] short_detect_config
);

  function automatic logic [15:0] dither_mask(input logic [2:0] d);
    unique case (d)
      3'h1:    dither_mask = 16'h0001;
      3'h2:    dither_mask = 16'h0003;
      3'h3:    dither_mask = 16'h0007;
      3'h4:    dither_mask = 16'h000f;
      default: dither_mask = 16'h0000;
    endcase
  endfunction

  logic [15:0] current_cfg;
  logic [15:0] dimspread_cfg;
  logic [15:0] lfsr;
  logic [8:0]  mod_cnt;
  logic        tri_down;
  logic        seen_wr;
  logic [15:0] ramp_level;

  // address decode
  wire        sel_brt   = (reg_addr == ldc_pkg::OFS_HOST_BRT);
  wire        sel_cur   = (reg_addr == ldc_pkg::OFS_CURRENT);
  wire        sel_dim   = (reg_addr == ldc_pkg::OFS_DIMSPREAD);
  wire        sel_short = (reg_addr == ldc_pkg::OFS_SHORT);
  wire [15:0] rd_mux    = sel_brt   ? host_brightness_value :
                          sel_cur   ? current_cfg :
                          sel_dim   ? dimspread_cfg :
                          sel_short ? short_detect_config : 16'h0000;

  // field views
  assign global_current_level =
    current_cfg[ldc_pkg::CUR_MSB:ldc_pkg::CUR_LSB];
  assign spread_pseudo_enable     = dimspread_cfg[ldc_pkg::PSEUDO_BIT];
  assign spread_modulation_rate   = dimspread_cfg[ldc_pkg::RATE_LSB+:2];
  assign spread_range             =
    dimspread_cfg[ldc_pkg::RANGE_LSB+:2];
  assign brightness_source_select = dimspread_cfg[ldc_pkg::SRC_LSB+:2];
  assign ramp_duration_select     = dimspread_cfg[ldc_pkg::RAMP_LSB+:3];
  assign dither_depth             = dimspread_cfg[ldc_pkg::DITHER_LSB+:3];
  assign smooth_ramp_enable       =
    dimspread_cfg[ldc_pkg::SMOOTH_BIT];

  // brightness source, reserved codes fall back to the pwm pin
  wire        host_src    = (brightness_source_select
                             == ldc_pkg::SRC_HOST);
  wire [15:0] bright_target = host_src ? host_brightness_value
                                       : pwm_duty;

  // spread modulation step rate
  wire [8:0]  mod_period = (spread_modulation_rate == 2'h0) ?
                             ldc_pkg::MOD_CYC_0 :
                           (spread_modulation_rate == 2'h1) ?
                             ldc_pkg::MOD_CYC_1 :
                           (spread_modulation_rate == 2'h2) ?
                             ldc_pkg::MOD_CYC_2 : ldc_pkg::MOD_CYC_3;
  wire        mod_tick   = (mod_cnt >= mod_period - 9'h001);
  wire        lfsr_fb    = lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10];
  wire [15:0] next_lfsr  = {lfsr[14:0], lfsr_fb};
  wire        tri_top    = (boost_oscillator_offset == 7'h7f);
  wire        tri_bot    = (boost_oscillator_offset == 7'h00);
  // turn at the ends instead of wrapping through zero
  wire        next_tri_down   = tri_down ? !tri_bot : tri_top;
  wire [6:0]  next_tri_offset = next_tri_down ?
                                  boost_oscillator_offset - 7'h01 :
                                  boost_oscillator_offset + 7'h01;

  // dither adds masked noise on top of the ramp level, saturating
  wire [16:0] dith_sum   = {1'b0, ramp_level}
                           + {1'b0, lfsr & dither_mask(dither_depth)};
  wire [15:0] next_duty  = dith_sum[16] ? 16'hffff : dith_sum[15:0];

  ldc_ramp #(
    .MS_CYC   (MS_CYC)
  ) u_ramp (
    .clk      (clk),
    .rst_n    (rst_n),
    .target   (bright_target),
    .dur_code (ramp_duration_select),
    .smooth   (smooth_ramp_enable),
    .level    (ramp_level)
  );

  // register writes, all bits stored as written
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      host_brightness_value <= ldc_pkg::RST_HOST_BRT;
      current_cfg           <= ldc_pkg::RST_CURRENT;
      dimspread_cfg         <= ldc_pkg::RST_DIMSPREAD;
      short_detect_config   <= ldc_pkg::RST_SHORT;
    end else if (reg_wr) begin
      if (sel_brt)
        host_brightness_value <= reg_wdata;
      if (sel_cur)
        current_cfg <= reg_wdata;
      if (sel_dim)
        dimspread_cfg <= reg_wdata;
      if (sel_short)
        short_detect_config <= reg_wdata;
    end
  end

  // read data, unmapped offsets read zero
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata    <= 16'h0000;
      reg_rd_valid <= 1'b0;
    end else begin
      reg_rd_valid <= reg_rd;
      if (reg_rd)
        reg_rdata <= rd_mux;
    end
  end

  // boost oscillator offset: triangle sweep or pseudo-random values
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mod_cnt                 <= 9'h000;
      tri_down                <= 1'b0;
      boost_oscillator_offset <= 7'h00;
      lfsr                    <= ldc_pkg::LFSR_SEED;
    end else begin
      lfsr    <= next_lfsr;
      mod_cnt <= mod_tick ? 9'h000 : mod_cnt + 9'h001;
      if (mod_tick) begin
        if (spread_pseudo_enable) begin
          boost_oscillator_offset <= lfsr[6:0];
        end else begin
          boost_oscillator_offset <= next_tri_offset;
          tri_down                <= next_tri_down;
        end
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n)
      brightness_duty <= 16'h0000;
    else
      brightness_duty <= next_duty;
  end

  // assertion helper: no write seen since reset
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n)
      seen_wr <= 1'b0;
    else if (reg_wr)
      seen_wr <= 1'b1;
  end

  a_current_write: assert property (@(posedge clk) disable iff (!rst_n)
    (reg_wr && sel_cur) |=>
      global_current_level == $past(reg_wdata[11:0]))
    else $error("current level not taken from write");

  a_pseudo_value: assert property (@(posedge clk) disable iff (!rst_n)
    (mod_tick && spread_pseudo_enable) |=>
      boost_oscillator_offset == $past(lfsr[6:0]))
    else $error("pseudo-random offset not applied");

  a_mod_spacing: assert property (@(posedge clk) disable iff (!rst_n)
    mod_tick |=> !mod_tick [*8])
    else $error("modulation steps too close");

  a_range_write: assert property (@(posedge clk) disable iff (!rst_n)
    (reg_wr && sel_dim) |=>
      spread_range == $past(reg_wdata[11:10]))
    else $error("spread range not taken from write");

  a_source_route: assert property (@(posedge clk) disable iff (!rst_n)
    (ramp_duration_select == 3'h0 && $stable(ramp_duration_select)
     && host_src && dither_depth == 3'h0 && !(reg_wr && sel_dim)) |=> ##1
      brightness_duty == $past(host_brightness_value, 2))
    else $error("host brightness not routed to duty");

  a_dither_off: assert property (@(posedge clk) disable iff (!rst_n)
    (dither_depth == 3'h0) |=> brightness_duty == $past(ramp_level))
    else $error("duty differs from ramp level without dither");

  a_dither_bound: assert property (@(posedge clk) disable iff (!rst_n)
    (dither_depth == 3'h4 && !ramp_level[15]) |=>
      (brightness_duty - $past(ramp_level)) <= 16'h000f)
    else $error("dither exceeds four bits");

  a_reset_values: assert property (@(posedge clk) disable iff (!rst_n)
    !seen_wr |-> (dimspread_cfg == ldc_pkg::RST_DIMSPREAD
                  && short_detect_config == ldc_pkg::RST_SHORT
                  && smooth_ramp_enable))
    else $error("configuration lost reset value");

  a_brt_readback: assert property (@(posedge clk) disable iff (!rst_n)
    (reg_wr && sel_brt) ##1 !reg_wr ##1 (reg_rd && sel_brt && !reg_wr) |=>
      reg_rdata == $past(reg_wdata, 3))
    else $error("host brightness read back wrong");

  a_config_keep: assert property (@(posedge clk) disable iff (!rst_n)
    (reg_wr && sel_dim) |=> dimspread_cfg == $past(reg_wdata))
    else $error("configuration word not stored whole");

endmodule // ldc_config_regs

/* tb/ldc_host_model.sv */
/*
  host controller model: issues single register writes and reads on the
  register access port of the led dimming configuration bank.
  assumes the bank takes requests on the rising clk edge and answers a
  read with a one-cycle valid pulse within a few cycles.
*/
`timescale 1ns/10ps
module ldc_host_model (
  // clock
  input  wire logic        clk,
  // register access port
  output logic             reg_wr,
  output logic             reg_rd,
  output logic      [7:0]  reg_addr,
  output logic      [15:0] reg_wdata,
  input  wire logic [15:0] reg_rdata,
  input  wire logic        reg_rd_valid
);
  initial begin
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    reg_addr  = 8'h5a;
    reg_wdata = 16'ha5a5;
  end

  // released lines show the inverse of the last value, never stale data
  task automatic write_reg(input logic [7:0] a, input logic [15:0] d);
    @(negedge clk);
    reg_wr    = 1'b1;
    reg_addr  = a;
    reg_wdata = d;
    @(posedge clk);
    @(negedge clk);
    reg_wr    = 1'b0;
    reg_addr  = ~a;
    reg_wdata = ~d;
  endtask

  task automatic read_reg(input logic [7:0] a, output logic [15:0] d);
    int n;
    @(negedge clk);
    reg_rd   = 1'b1;
    reg_addr = a;
    @(posedge clk);
    @(negedge clk);
    reg_rd   = 1'b0;
    reg_addr = ~a;
    d        = 16'hxxxx;
    for (n = 0; n < 4 && reg_rd_valid !== 1'b1; n++) @(negedge clk);
    if (reg_rd_valid === 1'b1) d = reg_rdata;
  endtask
endmodule // ldc_host_model

/* tb/tb_top.sv */
/*
  self-checking bench of the led dimming configuration register bank:
  reset values, random register traffic, brightness path and spread.
  assumes the host model drives the register port and MS_CYC = 512.
*/
`timescale 1ns/10ps
module tb_top;
  logic        clk, rst_n, reg_wr, reg_rd, reg_rd_valid, pseudo, smooth;
  logic [7:0]  reg_addr;
  logic [15:0] reg_wdata, reg_rdata, pwm_duty, host_brt, duty, short_cfg;
  logic [11:0] cur;
  logic [6:0]  osc_ofs;
  logic [1:0]  rate, range, src;
  logic [2:0]  ramp, dither;
  logic [15:0] e [4];
  logic [15:0] rd;
  logic [31:0] rs;
  int          bad_count, compares, cyc, i, k, n;
  int          hz [4] = '{200, 500, 800, 1200};

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  ldc_host_model host_u (.clk(clk), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_rd_valid(reg_rd_valid));

  ldc_config_regs #(.MS_CYC(512)) dut_u (.clk(clk), .rst_n(rst_n),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_rd_valid(reg_rd_valid), .pwm_duty(pwm_duty),
    .global_current_level(cur), .spread_pseudo_enable(pseudo),
    .spread_modulation_rate(rate), .spread_range(range),
    .boost_oscillator_offset(osc_ofs), .brightness_source_select(src),
    .ramp_duration_select(ramp), .dither_depth(dither),
    .smooth_ramp_enable(smooth), .host_brightness_value(host_brt),
    .brightness_duty(duty), .short_detect_config(short_cfg));

  function automatic logic [31:0] xorshift(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction

  task automatic check(input string name, input logic [15:0] seen,
                       input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic results();
    if (bad_count == 0 && compares > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  always @(posedge clk) begin
    cyc++;
    if (cyc == 60000) begin
      bad_count++;
      results();
    end
  end

  // writes through the host and mirrors the word in the expected image
  task automatic put(input logic [7:0] a, input logic [15:0] d);
    host_u.write_reg(a, d);
    if (a[7:3] == 5'h00 && a[0] == 1'b0) e[a[2:1]] = d;
  endtask

  task automatic check_all();
    for (k = 0; k < 4; k++) begin
      host_u.read_reg(8'(k * 2), rd);
      check("readback", rd, e[k]);
    end
    check("current", 16'(cur), 16'(e[1][11:0]));
    check("pseudo", 16'(pseudo), 16'(e[2][14]));
    check("rate", 16'(rate), 16'(e[2][13:12]));
    check("range", 16'(range), 16'(e[2][11:10]));
    check("source", 16'(src), 16'(e[2][9:8]));
    check("ramp", 16'(ramp), 16'(e[2][7:5]));
    check("dither", 16'(dither), 16'(e[2][4:2]));
    check("smooth", 16'(smooth), 16'(e[2][1]));
    check("host_brt", host_brt, e[0]);
    check("short", short_cfg, e[3]);
  endtask

  initial begin
    rst_n = 1'b0;
    pwm_duty = 16'h1234;
    rs = 32'd69757;
    e = '{16'h0000, 16'h0fff, 16'h08a3, 16'h0100};
    repeat (16) @(negedge clk);
    rst_n = 1'b1;
    check_all();
    host_u.read_reg(8'h08, rd);
    check("unmapped", rd, 16'h0000);
    for (i = 0; i < 40; i++) begin
      rs = xorshift(rs);
      rd = rs[15:0];
      if (rs[18:17] == 2'h2) begin
        rd[8] = 1'b0;
        if (rd[7:5] == 3'h1 || rd[7:5] == 3'h2) rd[1] = 1'b0;
      end
      put({5'h00, rs[18:17], 1'b0}, rd);
      if (i % 8 == 7) check_all();
    end
    put(8'h04, 16'hc000);
    put(8'h02, 16'hf000);
    check_all();
    for (i = 0; i < 4; i++) begin
      rs = xorshift(rs);
      @(negedge clk);
      pwm_duty = rs[15:0];
      repeat (4) @(negedge clk);
      check("pwm_path", duty, pwm_duty);
    end
    put(8'h04, 16'h0200);
    put(8'h00, 16'h0000);
    host_u.read_reg(8'h00, rd);
    check("brt_read", rd, 16'h0000);
    repeat (4) @(negedge clk);
    check("host_path", duty, 16'h0000);
    put(8'h04, 16'h0220);
    put(8'h00, 16'hffff);
    repeat (100) @(negedge clk);
    check("ramp_mid", 16'(duty != 16'hffff && duty != 16'h0), 16'h1);
    repeat (500) @(negedge clk);
    check("ramp_end", duty, 16'hffff);
    put(8'h04, 16'h0262);
    put(8'h00, 16'h0000);
    repeat (28000) @(negedge clk);
    check("smooth_long", 16'(duty != 16'h0000), 16'h1);
    put(8'h04, 16'h0010);
    @(negedge clk);
    pwm_duty = 16'h4000;
    repeat (4) @(negedge clk);
    n = 0;
    for (i = 0; i < 16; i++) begin
      @(negedge clk);
      if (duty !== 16'h4000) n++;
      check("dith_max", 16'(duty - 16'h4000 < 16'h0010), 16'h1);
    end
    check("dither_on", 16'(n > 0), 16'h1);
    for (i = 0; i < 4; i++) begin
      put(8'h04, 16'(i) << 12);
      rd = 16'(osc_ofs);
      for (k = 0; k < 1000 && 16'(osc_ofs) === rd; k++) @(negedge clk);
      rd = 16'(osc_ofs);
      n = 0;
      for (k = 0; k < 1000 && 16'(osc_ofs) === rd; k++) begin
        @(negedge clk);
        n++;
      end
      check("mod_tick", 16'(n), 16'(10_000_000 / (hz[i] * 128)));
      check("tri_step", 16'(osc_ofs - rd[6:0] == 7'h01 ||
                            rd[6:0] - osc_ofs == 7'h01), 16'h1);
    end
    results();
  end
endmodule // tb_top
